// File: hw/iow_host.sv
// iow_host: host end, drives port cycles from software registers
`timescale 1ns/1ps
`default_nettype none
module iow_host (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // software port
    input  wire logic [3:0] sw_addr_i,
    input  wire logic [7:0] sw_wdata_i,
    input  wire logic       sw_wr_i,
    input  wire logic       sw_rd_i,
    output logic      [7:0] sw_rdata_o,
    output logic            irq_o,
    // i/o port
    iow_if.host             io
);
    import iow_pkg::*;

    logic [7:0]       ivl;
    logic             mode_irq;
    logic             wr_q;
    logic             rd_q;
    logic             armed;
    logic [7:0]       last_rd;
    logic             rd_pend;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [IRQ_W-1:0] ev;
    logic             go_wr;
    logic             go_rd;

    assign go_wr = sw_wr_i && sw_addr_i == CR_CTRL && sw_wdata_i[CTRL_GO_WR];
    assign go_rd = sw_wr_i && sw_addr_i == CR_CTRL && sw_wdata_i[CTRL_GO_RD];

    // ==================================================================
    // configuration
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ivl      <= IVL_MIN;
            mode_irq <= 1'b0;
            irq_en   <= '0;
        end else if (sw_wr_i) begin
            if (sw_addr_i == CR_IVL) begin
                // out of range codes are clamped to keep within 01..3f
                if (sw_wdata_i < IVL_MIN) begin
                    ivl <= IVL_MIN;
                end else if (sw_wdata_i > IVL_MAX) begin
                    ivl <= IVL_MAX;
                end else begin
                    ivl <= sw_wdata_i;
                end
            end else if (sw_addr_i == CR_CTRL) begin
                mode_irq <= sw_wdata_i[CTRL_MODE_IRQ];
            end else if (sw_addr_i == CR_IRQ_EN) begin
                irq_en <= sw_wdata_i[IRQ_W-1:0];
            end
        end
    end

    // ==================================================================
    // port cycles: one cycle strobes, write wins if both requested
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            rd_pend <= 1'b0;
            armed   <= 1'b0;
            last_rd <= 8'h00;
        end else begin
            wr_q    <= go_wr;
            rd_q    <= go_rd && !go_wr;
            rd_pend <= rd_q;
            if (go_wr) begin
                armed <= 1'b1;
            end else if (go_rd) begin
                armed <= 1'b0;
            end
            if (rd_pend) begin
                last_rd <= io.io_rdata;
            end
        end
    end

    assign io.io_wr    = wr_q;
    assign io.io_rd    = rd_q;
    assign io.io_addr  = WDT_PORT_ADDR;
    assign io.io_wdata = ivl;

    // ==================================================================
    // interrupts: set wins over clear
    assign ev[IRQ_DONE]   = rd_pend;
    assign ev[IRQ_EXPIRE] = io.wdt_irq || io.wdt_reset;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= ((sw_wr_i && sw_addr_i == CR_IRQ_CLR) ?
                         (irq_stat & ~sw_wdata_i[IRQ_W-1:0]) : irq_stat) | ev;
        end
    end
    assign irq_o = |(irq_stat & irq_en);

    // ==================================================================
    // software read data, one cycle after strobe
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sw_rdata_o <= 8'h00;
        end else if (sw_rd_i) begin
            if (sw_addr_i == CR_CTRL) begin
                sw_rdata_o <= {5'b0_0000, mode_irq, 2'b00};
            end else if (sw_addr_i == CR_IVL) begin
                sw_rdata_o <= ivl;
            end else if (sw_addr_i == CR_STAT) begin
                sw_rdata_o <= {5'b0_0000, io.wdt_irq, io.wdt_reset, armed};
            end else if (sw_addr_i == CR_IRQ_STAT) begin
                sw_rdata_o <= {6'b00_0000, irq_stat};
            end else if (sw_addr_i == CR_IRQ_EN) begin
                sw_rdata_o <= {6'b00_0000, irq_en};
            end else if (sw_addr_i == CR_RDATA) begin
                sw_rdata_o <= last_rd;
            end else begin
                sw_rdata_o <= 8'h00;
            end
        end else begin
            sw_rdata_o <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// File: hw/iow_pkg.sv
// iow_pkg: constants shared by both ends of the i/o port watchdog
package iow_pkg;
    // ==================================================================
    // port map
    localparam logic [15:0] WDT_PORT_ADDR = 16'h0443;
    localparam logic [7:0]  IVL_MIN       = 8'h01;
    localparam logic [7:0]  IVL_MAX       = 8'h3f;
    localparam int          IVL_W         = 6;
    // ==================================================================
    // timing
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          TICK_SEC      = 1;
    localparam int          TICK_CYCLES   = CLK_HZ * TICK_SEC;
    // ==================================================================
    // controller registers (word index on the software port)
    localparam logic [3:0]  CR_CTRL       = 4'h0;
    localparam logic [3:0]  CR_IVL        = 4'h1;
    localparam logic [3:0]  CR_STAT       = 4'h2;
    localparam logic [3:0]  CR_IRQ_STAT   = 4'h3;
    localparam logic [3:0]  CR_IRQ_CLR    = 4'h4;
    localparam logic [3:0]  CR_IRQ_EN     = 4'h5;
    localparam logic [3:0]  CR_RDATA      = 4'h6;
    // ctrl bits
    localparam int          CTRL_GO_WR    = 0;
    localparam int          CTRL_GO_RD    = 1;
    localparam int          CTRL_MODE_IRQ = 2;
    // irq status bits
    localparam int          IRQ_DONE      = 0;
    localparam int          IRQ_EXPIRE    = 1;
    localparam int          IRQ_W         = 2;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
endpackage

// File: hw/iow_if.sv
// iow_if: i/o port cycle between host and watchdog
`timescale 1ns/1ps
`default_nettype none
interface iow_if;
    logic        io_wr;
    logic        io_rd;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        wdt_reset;
    logic        wdt_irq;
    modport host (output io_wr, io_rd, io_addr, io_wdata,
                  input io_rdata, wdt_reset, wdt_irq);
    modport dev  (input io_wr, io_rd, io_addr, io_wdata,
                  output io_rdata, wdt_reset, wdt_irq);
endinterface
`default_nettype wire

// File: hw/iow_dev.sv
// iow_dev: watchdog device end, i/o port 443 hex
`timescale 1ns/1ps
`default_nettype none
module iow_dev #(
    parameter int TICK_N = iow_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // strap: expiry gives interrupt instead of reset
    input  wire logic irq_mode_i,
    // i/o port
    iow_if.dev        io
);
    import iow_pkg::*;

    typedef enum logic [1:0] {
        IOW_OFF = 2'b01,
        IOW_RUN = 2'b10
    } iow_state_e;

    iow_state_e               state;
    logic [IVL_W-1:0]         count;
    logic [31:0]              tick_cnt;
    logic                     tick;
    logic                     hit_wr;
    logic                     hit_rd;
    logic                     expire;
    logic                     mode_meta;
    logic                     mode_irq;

    assign hit_wr = io.io_wr && (io.io_addr == WDT_PORT_ADDR);
    assign hit_rd = io.io_rd && (io.io_addr == WDT_PORT_ADDR);
    assign tick   = (tick_cnt == 32'(TICK_N - 1));
    assign expire = (state == IOW_RUN) && tick && (count <= 6'h01);

    // ==================================================================
    // mode strap is a pin: two flops before any logic reads it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_meta <= 1'b0;
            mode_irq  <= 1'b0;
        end else begin
            mode_meta <= irq_mode_i;
            mode_irq  <= mode_meta;
        end
    end

    // ==================================================================
    // one second timebase, restarted by every refresh
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_cnt <= 32'h0000_0000;
        end else if (hit_wr || state != IOW_RUN || tick) begin
            tick_cnt <= 32'h0000_0000;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end

    // ==================================================================
    // state and countdown
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= IOW_OFF;
            count <= '0;
        end else begin
            case (state)
                IOW_OFF: begin
                    if (hit_wr) begin
                        state <= IOW_RUN;
                        count <= io.io_wdata[IVL_W-1:0];
                    end
                end
                IOW_RUN: begin
                    if (hit_wr) begin
                        count <= io.io_wdata[IVL_W-1:0];
                    end else if (hit_rd) begin
                        state <= IOW_OFF;
                    end else if (expire) begin
                        state <= IOW_OFF; // one shot per load
                        count <= '0;
                    end else if (tick) begin
                        count <= count - 6'h01;
                    end
                end
                default: begin
                    state <= IOW_OFF;
                end
            endcase
        end
    end

    // ==================================================================
    // timeout action, one cycle pulse; irq line level until read or write
    logic rst_q;
    logic irq_q;
    logic [7:0] rdata_q;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            rst_q <= expire && !mode_irq && !hit_wr && !hit_rd;
            if (expire && mode_irq && !hit_wr && !hit_rd) begin
                irq_q <= 1'b1;
            end else if (hit_wr || hit_rd) begin
                irq_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= {2'b00, count};
        end
    end

    assign io.wdt_reset = rst_q;
    assign io.wdt_irq   = irq_q;
    assign io.io_rdata  = rdata_q;
endmodule
`default_nettype wire

// File: test/iow_checker.sv
// iow_checker: assertions on the port link between host and watchdog
`timescale 1ns/1ps
`default_nettype none
module iow_checker
    import iow_pkg::*;
#(
    parameter int TICK_N = 10
) (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [15:0] io_addr,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        wdt_reset,
    input wire logic        wdt_irq
);
    // ==========================================
    // helper: armed flag, loaded code, cycles since load
    logic        armed;
    logic [5:0]  code;
    logic [15:0] cyc;
    wire         hit  = io_addr == WDT_PORT_ADDR;
    wire  [15:0] span = 16'(code * TICK_N);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            armed <= 1'b0;
            code  <= 6'h00;
            cyc   <= 16'h0000;
        end else begin
            cyc   <= (io_wr && hit) ? 16'h0000 : cyc + 16'h0001;
            code  <= (io_wr && hit) ? io_wdata[5:0] : code;
            armed <= (io_wr && hit) ? 1'b1
                   : ((io_rd && hit) || wdt_reset || wdt_irq) ? 1'b0 : armed;
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_load;
        io_wr && hit;
    endsequence
    sequence s_fire;
        wdt_reset || $rose(wdt_irq);
    endsequence
    // read data is a flop of the count, so it trails the load by one more cycle
    a_load_count: assert property (s_load |-> ##2 io_rdata == {2'b00, code})
        else $error("count not loaded from port write");
    a_hold_tick: assert property (s_load ##2 1 |=> $stable(io_rdata) [*8])
        else $error("count moved before a full tick");
    a_fire_armed: assert property (s_fire |-> armed)
        else $error("timeout action while disabled");
    a_fire_time: assert property (s_fire |-> cyc + 16'h0002 >= span && cyc <= span + 16'h0002)
        else $error("timeout action at wrong time");
    a_fire_zero: assert property (s_fire |-> $past(io_rdata) <= 8'h01)
        else $error("timeout action before count ran out");
    a_reset_pulse: assert property (wdt_reset |=> !wdt_reset)
        else $error("reset pulse too long");
    a_irq_holds: assert property (wdt_irq && !io_wr && !io_rd |=> wdt_irq)
        else $error("interrupt dropped without port access");
    a_host_range: assert property (io_wr |-> hit && io_wdata >= IVL_MIN && io_wdata <= IVL_MAX)
        else $error("port write outside address or code range");
endmodule
`default_nettype wire

// File: test/io_port_watchdog_timer_test.sv
// io_port_watchdog_timer_test: scenario bench for both watchdog ends
`timescale 1ns/1ps
`default_nettype none
module io_port_watchdog_timer_test;
    import iow_pkg::*;
    localparam int TN = 10;
    logic       clk_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       mode = 1'b0;
    logic [3:0] sw_addr_i = 4'h0;
    logic [7:0] sw_wdata_i = 8'h00;
    logic       sw_wr_i = 1'b0;
    logic       sw_rd_i = 1'b0;
    logic [7:0] sw_rdata_o;
    logic       irq_o;
    int         err_total = 0;
    int         n_checks = 0;
    int         cycles = 0;
    int         n;
    iow_if io ();
    iow_host i_iow_host (.clk_i, .rstn_i, .sw_addr_i, .sw_wdata_i, .sw_wr_i,
                         .sw_rd_i, .sw_rdata_o, .irq_o, .io(io));
    // short tick so a second is ten cycles
    iow_dev #(.TICK_N(TN)) i_iow_dev (.clk_i, .rstn_i, .irq_mode_i(mode), .io(io));
    iow_checker #(.TICK_N(TN)) i_iow_checker (.clk_i, .rstn_i, .io_wr(io.io_wr),
        .io_rd(io.io_rd), .io_addr(io.io_addr), .io_wdata(io.io_wdata),
        .io_rdata(io.io_rdata), .wdt_reset(io.wdt_reset), .wdt_irq(io.wdt_irq));
    always #12.5 clk_i = ~clk_i;
    // ==========================================
    // common tasks
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t: seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sw_wr_i <= 1'b1;
        sw_addr_i <= a;
        sw_wdata_i <= d;
        @(posedge clk_i);
        sw_wr_i <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        sw_rd_i <= 1'b1;
        sw_addr_i <= a;
        @(posedge clk_i);
        sw_rd_i <= 1'b0;
        #1 chk(sw_rdata_o, exp);
    endtask
    // bounded wait; n == lim means nothing fired
    task automatic wait_fire(input int lim);
        n = 0;
        while (!(io.wdt_reset || io.wdt_irq) && n < lim) begin
            @(posedge clk_i);
            #1 n++;
        end
    endtask
    // ==========================================
    // scenarios
    task automatic t_fire();
        wr(CR_IVL, 8'h03);
        wr(CR_IRQ_EN, 8'h02);
        wr(CR_CTRL, 8'h01);
        wait_fire(200);
        chk({7'h00, n inside {[3*TN-1:3*TN+5]}}, 8'h01);
        chk({7'h00, io.wdt_reset}, 8'h01);
        rc(CR_IRQ_STAT, 8'h02);
        chk({7'h00, irq_o}, 8'h01);
        wr(CR_IRQ_CLR, 8'h02);
        rc(CR_IRQ_STAT, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
    endtask
    task automatic t_clamp();
        wr(CR_IVL, 8'h00);
        rc(CR_IVL, 8'h01);
        wr(CR_IVL, 8'hff);
        rc(CR_IVL, 8'h3f);
        rc(4'hf, 8'h00);
        wr(CR_CTRL, 8'h04);
        rc(CR_CTRL, 8'h04);
    endtask
    // read-done is masked, so irq_o stays low
    task automatic t_disable();
        wr(CR_IVL, 8'h01);
        wr(CR_CTRL, 8'h01);
        repeat (3) @(posedge clk_i);
        wr(CR_CTRL, 8'h02);
        wait_fire(4*TN);
        chk({7'h00, n == 4*TN}, 8'h01);
        rc(CR_RDATA, 8'h01);
        rc(CR_IRQ_STAT, 8'h01);
        rc(CR_STAT, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
        wr(CR_IRQ_CLR, 8'h03);
    endtask
    task automatic t_refresh();
        mode <= 1'b1;
        wr(CR_IVL, 8'h02);
        wr(CR_CTRL, 8'h01);
        repeat (15) @(posedge clk_i);
        wr(CR_CTRL, 8'h01);
        wait_fire(200);
        chk({7'h00, n inside {[2*TN-1:2*TN+5]}}, 8'h01);
        chk({7'h00, io.wdt_irq}, 8'h01);
        rc(CR_IRQ_STAT, 8'h02);
        rc(CR_STAT, 8'h05);
        wr(CR_CTRL, 8'h02);
        repeat (2) @(posedge clk_i);
        #1 chk({7'h00, io.wdt_irq}, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_fire();
        t_clamp();
        t_disable();
        t_refresh();
        end_sim();
    end
endmodule
`default_nettype wire
